// ---- jkb_jog_ctrl.sv ----
// Jog key, release arbitration, brake sequencing and stall detection.
// Assumes synchronous key inputs and an Avalon-MM master with waitrequest.
//
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module jkb_jog_ctrl
   import jkb_pkg::*;
#(
   parameter int CLOSE_MS = BRAKE_CLOSE_MS,
   parameter int WAIT_MS = BRAKE_WAIT_MS,
   parameter int TICK_CYCLES = MS_CYCLES
)
(
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic [5:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_key_up,
   input wire logic i_key_dn,
   input wire logic i_bus_connected,
   input wire logic i_preop,
   input wire logic [6:0] i_node_address,
   input wire logic i_speed_low,
   output logic o_step_pulse,
   output logic o_step_dir_up,
   output logic o_brake_release,
   output logic o_moving
);
   initial
   begin
      if (CLOSE_MS < 1 || WAIT_MS < 1)
         $error("Brake times must be at least 1 ms");
      if (TICK_CYCLES < 16 || TICK_CYCLES > 131072)
         $error("Tick length out of range");
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   logic [15:0] ctrl_ff;
   logic keyen_ff;
   logic [31:0] step_ff, idle_ff, uplim_ff, lolim_ff, backoff_ff, pos_ff;
   logic [15:0] brwait_ff, brclose_ff, stalltim_ff;
   logic [7:0] stallpct_ff;
   logic [1:0] cfg_ff;
   logic err_ff;
   logic ack_ff;
   logic [3:0] widx;
   logic wr_go, rd_go;
   assign widx = i_avs_address[5:2];
   assign wr_go = i_avs_write && ack_ff;
   assign rd_go = i_avs_read && !ack_ff;
   assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_ff;

   always_ff @(posedge i_clock)
   begin
      if (i_reset)
         ack_ff <= 1'b0;
      else
         ack_ff <= (i_avs_read || i_avs_write) && !ack_ff;
   end

   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         ctrl_ff <= 16'h0000;
         keyen_ff <= 1'b0;
         step_ff <= STEP_RST;
         idle_ff <= IDLE_RST;
         uplim_ff <= UPLIM_RST;
         lolim_ff <= LOLIM_RST;
         brwait_ff <= 16'(WAIT_MS);
         backoff_ff <= BACKOFF_RST;
         brclose_ff <= 16'(CLOSE_MS);
         stallpct_ff <= STALL_PCT_RST;
         stalltim_ff <= 16'(STALL_TIME_MS);
         cfg_ff <= 2'b00;
      end
      else if (wr_go)
      begin
         case (widx)
            REG_CTRL: ctrl_ff <= i_avs_writedata[15:0];
            REG_KEYEN: keyen_ff <= i_avs_writedata[0];
            REG_STEP: step_ff <= i_avs_writedata;
            REG_IDLE: idle_ff <= i_avs_writedata;
            REG_UPLIM: uplim_ff <= i_avs_writedata;
            REG_LOLIM: lolim_ff <= i_avs_writedata;
            REG_BRWAIT: brwait_ff <= i_avs_writedata[15:0];
            REG_BACKOFF: backoff_ff <= i_avs_writedata;
            REG_BRCLOSE: brclose_ff <= i_avs_writedata[15:0];
            REG_STALLPCT: stallpct_ff <= i_avs_writedata[7:0];
            REG_STALLTIM: stalltim_ff <= i_avs_writedata[15:0];
            REG_CFG: cfg_ff <= i_avs_writedata[1:0];
            default: ;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Key enable and release arbitration
   // -----------------------------------------------------------------
   logic standalone, keys_en, sim_en, cont_ok, bus_mode;
   logic key_up, key_dn, both, any_key;
   assign standalone = keyen_ff && i_preop;
   always_comb
   begin
      if (!i_bus_connected)
         keys_en = (i_node_address <= 7'h01) || keyen_ff;
      else if (standalone)
         keys_en = 1'b1;
      else
         keys_en = ctrl_ff[CW_JOG_REL] && !ctrl_ff[CW_BUS_REL];
   end
   // Everything else leaves keys_en low
   assign sim_en = i_bus_connected && !ctrl_ff[CW_BUS_REL] &&
      !ctrl_ff[CW_JOG_REL] && !standalone;
   assign key_up = (keys_en && i_key_up) ||
      (sim_en && ctrl_ff[CW_SIM_UP]);
   assign key_dn = (keys_en && i_key_dn) || (sim_en && ctrl_ff[CW_SIM_DN]);
   assign both = key_up && key_dn;
   assign any_key = key_up || key_dn;
   assign cont_ok = !i_bus_connected || standalone ||
      ctrl_ff[CW_CONT_REL];
   assign bus_mode = ctrl_ff[CW_BUS_REL] && !standalone;

   // -----------------------------------------------------------------
   // Run sequencer
   // -----------------------------------------------------------------
   jkb_state_t state_ff;
   logic dir_ff, manual_ff, busrun_ff;
   logic [31:0] cnt_ff, tmr_ff;
   logic [16:0] ms_ff;
   logic tick;
   logic [15:0] close_ms_ff;
   logic brake_ff;
   logic at_limit, mode_abort, step_go;
   assign tick = (ms_ff == 17'(TICK_CYCLES - 1));
   assign at_limit = dir_ff ? (pos_ff >= uplim_ff) : (pos_ff <= lolim_ff);
   assign mode_abort = (!busrun_ff && !keys_en && !sim_en) ||
      (busrun_ff && !bus_mode);
   assign step_go = (ms_ff[3:0] == 4'h0);

   always_ff @(posedge i_clock)
   begin
      if (i_reset || tick)
         ms_ff <= 17'h00000;
      else
         ms_ff <= ms_ff + 17'h00001;
   end

   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         state_ff <= ST_IDLE;
         dir_ff <= 1'b1;
         manual_ff <= 1'b0;
         busrun_ff <= 1'b0;
         cnt_ff <= 32'h0;
         tmr_ff <= 32'h0;
      end
      else
      begin
         case (state_ff)
            ST_IDLE:
            begin
               if (bus_mode && !err_ff &&
                  (ctrl_ff[CW_MAN_UP] ^ ctrl_ff[CW_MAN_DN]))
               begin
                  state_ff <= ST_BRAKE_WAIT;
                  dir_ff <= ctrl_ff[CW_MAN_UP];
                  busrun_ff <= 1'b1;
                  manual_ff <= 1'b1;
                  tmr_ff <= 32'h0;
               end
               else if (any_key && !both)
               begin
                  state_ff <= ST_BRAKE_WAIT;
                  dir_ff <= key_up;
                  busrun_ff <= 1'b0;
                  manual_ff <= 1'b0;
                  tmr_ff <= 32'h0;
               end
            end
            ST_BRAKE_WAIT:
            begin
               if (tick)
                  tmr_ff <= tmr_ff + 32'h1;
               if (cfg_ff[0] && brake_ff)
               begin
                  state_ff <= ST_STEP;
                  cnt_ff <= 32'h0;
               end
               else if (cfg_ff[0] && tmr_ff >= 32'(brwait_ff))
               begin
                  state_ff <= ST_BACKOFF;
                  cnt_ff <= 32'h0;
               end
               else if (cfg_ff[1] && tmr_ff >= 32'(FRICTION_IDLE_MS))
               begin
                  state_ff <= ST_STEP;
                  cnt_ff <= 32'h0;
               end
               else if (cfg_ff == 2'b00)
               begin
                  state_ff <= ST_STEP;
                  cnt_ff <= 32'h0;
               end
            end
            ST_BACKOFF:
            begin
               if (step_go)
                  cnt_ff <= cnt_ff + 32'h1;
               if (cnt_ff >= backoff_ff)
               begin
                  state_ff <= ST_STEP;
                  cnt_ff <= 32'h0;
               end
            end
            ST_STEP:
            begin
               if (step_go)
                  cnt_ff <= cnt_ff + 32'h1;
               if (!busrun_ff && both)
                  state_ff <= ST_LOCK;
               else if (mode_abort || at_limit)
                  state_ff <= ST_IDLE;
               else if (manual_ff)
                  state_ff <= ST_CONT;
               else if (cnt_ff >= step_ff)
               begin
                  state_ff <= ST_HOLD;
                  tmr_ff <= 32'h0;
               end
            end
            ST_HOLD:
            begin
               if (tick)
                  tmr_ff <= tmr_ff + 32'h1;
               if (both)
                  state_ff <= ST_LOCK;
               else if (!any_key || mode_abort)
                  state_ff <= ST_IDLE;
               else if (cont_ok && tmr_ff >= idle_ff)
                  state_ff <= ST_CONT;
            end
            ST_CONT:
            begin
               if (!busrun_ff && both)
                  state_ff <= ST_LOCK;
               else if (mode_abort || at_limit || err_ff)
                  state_ff <= ST_IDLE;
               else if (!busrun_ff && !(dir_ff ? key_up : key_dn))
                  state_ff <= ST_IDLE;
               else if (busrun_ff && !ctrl_ff[CW_MAN_UP] &&
                  !ctrl_ff[CW_MAN_DN])
                  state_ff <= ST_IDLE;
            end
            ST_LOCK:
            begin
               if (!key_up && !key_dn)
                  state_ff <= ST_IDLE;
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Motion output and position
   // -----------------------------------------------------------------
   logic moving;
   assign moving = (state_ff == ST_STEP) || (state_ff == ST_CONT) ||
      (state_ff == ST_BACKOFF);
   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         o_step_pulse <= 1'b0;
         o_step_dir_up <= 1'b0;
         o_moving <= 1'b0;
         pos_ff <= POS_RST;
      end
      else
      begin
         o_moving <= moving;
         o_step_pulse <= moving && step_go &&
            !(state_ff != ST_BACKOFF && at_limit);
         o_step_dir_up <= (state_ff == ST_BACKOFF) ? !dir_ff : dir_ff;
         if (moving && step_go && !(state_ff != ST_BACKOFF && at_limit))
         begin
            if ((state_ff == ST_BACKOFF) ? !dir_ff : dir_ff)
               pos_ff <= pos_ff + 32'h1;
            else
               pos_ff <= pos_ff - 32'h1;
         end
      end
   end

   // -----------------------------------------------------------------
   // Brake control
   // -----------------------------------------------------------------
   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         brake_ff <= 1'b0;
         close_ms_ff <= 16'h0;
      end
      else if (state_ff == ST_BACKOFF || (state_ff == ST_STEP && cfg_ff[1]))
      begin
         brake_ff <= 1'b1;
         close_ms_ff <= 16'h0;
      end
      else if (state_ff == ST_IDLE || state_ff == ST_LOCK)
      begin
         if (cfg_ff[1])
            brake_ff <= 1'b0;
         else if (brake_ff && tick)
         begin
            close_ms_ff <= close_ms_ff + 16'h1;
            if (close_ms_ff + 16'h1 >= brclose_ff)
               brake_ff <= 1'b0;
         end
      end
      else
         close_ms_ff <= 16'h0;
   end
   assign o_brake_release = brake_ff;

   // -----------------------------------------------------------------
   // Stall detection
   // -----------------------------------------------------------------
   logic [15:0] slow_ms_ff;
   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         slow_ms_ff <= 16'h0;
         err_ff <= 1'b0;
      end
      else
      begin
         if (state_ff == ST_CONT && i_speed_low)
         begin
            if (tick)
               slow_ms_ff <= slow_ms_ff + 16'h1;
         end
         else
            slow_ms_ff <= 16'h0;
         if (state_ff == ST_CONT && slow_ms_ff > stalltim_ff)
            err_ff <= 1'b1;
         else if (wr_go && widx == REG_CTRL &&
            (i_avs_writedata[CW_MAN_UP] ^ i_avs_writedata[CW_MAN_DN]) &&
            (i_avs_writedata[1:0] != ctrl_ff[1:0]))
            err_ff <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Read data
   // -----------------------------------------------------------------
   always_ff @(posedge i_clock)
   begin
      if (i_reset)
         o_avs_readdata <= 32'h0;
      else if (rd_go)
      begin
         case (widx)
            REG_CTRL: o_avs_readdata <= {16'h0, ctrl_ff};
            REG_STAT: o_avs_readdata <= {21'h0, err_ff, 3'h0, o_moving,
               1'b0, brake_ff, both, keys_en, sim_en, cont_ok};
            REG_KEYEN: o_avs_readdata <= {31'h0, keyen_ff};
            REG_STEP: o_avs_readdata <= step_ff;
            REG_IDLE: o_avs_readdata <= idle_ff;
            REG_UPLIM: o_avs_readdata <= uplim_ff;
            REG_LOLIM: o_avs_readdata <= lolim_ff;
            REG_BRWAIT: o_avs_readdata <= {16'h0, brwait_ff};
            REG_BACKOFF: o_avs_readdata <= backoff_ff;
            REG_BRCLOSE: o_avs_readdata <= {16'h0, brclose_ff};
            REG_STALLPCT: o_avs_readdata <= {24'h0, stallpct_ff};
            REG_STALLTIM: o_avs_readdata <= {16'h0, stalltim_ff};
            REG_POS: o_avs_readdata <= pos_ff;
            REG_CFG: o_avs_readdata <= {30'h0, cfg_ff};
            default: o_avs_readdata <= 32'h0;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   property p_lock_hold;
      @(posedge i_clock) disable iff (i_reset)
      (state_ff == ST_LOCK && (key_up || key_dn)) |=> state_ff == ST_LOCK;
   endproperty
   a_lock_hold: assert property (p_lock_hold)
      else $error("Lock left while a key held");
   property p_both_abort;
      @(posedge i_clock) disable iff (i_reset)
      (state_ff == ST_CONT && !busrun_ff && both) |=> state_ff == ST_LOCK;
   endproperty
   a_both_abort: assert property (p_both_abort)
      else $error("Both keys did not abort run");
   property p_no_cont;
      @(posedge i_clock) disable iff (i_reset)
      (state_ff == ST_HOLD && !cont_ok) |=> state_ff != ST_CONT;
   endproperty
   a_no_cont: assert property (p_no_cont)
      else $error("Continuous run without release");
   property p_keys_standalone;
      @(posedge i_clock) disable iff (i_reset)
      (i_bus_connected && keyen_ff && i_preop) |-> keys_en && !sim_en;
   endproperty
   a_keys_standalone: assert property (p_keys_standalone)
      else $error("Standalone keys not enabled");
   property p_keys_off;
      @(posedge i_clock) disable iff (i_reset)
      (i_bus_connected && !standalone && ctrl_ff[CW_BUS_REL]) |-> !keys_en;
   endproperty
   a_keys_off: assert property (p_keys_off)
      else $error("Keys enabled under bus release");
   property p_limit;
      @(posedge i_clock) disable iff (i_reset)
      (state_ff == ST_CONT && at_limit && !(both && !busrun_ff)) |=>
         state_ff == ST_IDLE;
   endproperty
   a_limit: assert property (p_limit)
      else $error("Run passed travel limit");
   property p_stall;
      @(posedge i_clock) disable iff (i_reset)
      (state_ff == ST_CONT && slow_ms_ff > stalltim_ff) |=> err_ff;
   endproperty
   a_stall: assert property (p_stall)
      else $error("Stall not flagged");
   property p_mode_abort;
      @(posedge i_clock) disable iff (i_reset)
      (state_ff == ST_CONT && busrun_ff && !bus_mode) |=> state_ff == ST_IDLE;
   endproperty
   a_mode_abort: assert property (p_mode_abort)
      else $error("Mode change did not abort");
   c_cont: cover property (@(posedge i_clock) state_ff == ST_CONT);
   c_lock: cover property (@(posedge i_clock) state_ff == ST_LOCK);
   c_err: cover property (@(posedge i_clock) err_ff);
endmodule
`default_nettype wire

// ---- jkb_pkg.sv ----
// Package for the jog key and brake control block.
// Assumes a 100 MHz clock and an Avalon-MM register slave.
package jkb_pkg;
   // -----------------------------------------------------------------
   // Register word offsets (byte address / 4)
   // -----------------------------------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h1;
   localparam logic [3:0] REG_KEYEN = 4'h2;
   localparam logic [3:0] REG_STEP = 4'h3;
   localparam logic [3:0] REG_IDLE = 4'h4;
   localparam logic [3:0] REG_UPLIM = 4'h5;
   localparam logic [3:0] REG_LOLIM = 4'h6;
   localparam logic [3:0] REG_BRWAIT = 4'h7;
   localparam logic [3:0] REG_BACKOFF = 4'h8;
   localparam logic [3:0] REG_BRCLOSE = 4'h9;
   localparam logic [3:0] REG_STALLPCT = 4'ha;
   localparam logic [3:0] REG_STALLTIM = 4'hb;
   localparam logic [3:0] REG_POS = 4'hc;
   localparam logic [3:0] REG_CFG = 4'hd;
   // -----------------------------------------------------------------
   // Control and status bit positions
   // -----------------------------------------------------------------
   localparam int CW_MAN_UP = 0;
   localparam int CW_MAN_DN = 1;
   localparam int CW_CONT_REL = 3;
   localparam int CW_BUS_REL = 4;
   localparam int CW_JOG_REL = 5;
   localparam int CW_SIM_UP = 8;
   localparam int CW_SIM_DN = 9;
   localparam int SW_MOVING = 6;
   localparam int SW_POS_ERR = 10;
   // -----------------------------------------------------------------
   // Reset values and times
   // -----------------------------------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int BRAKE_WAIT_MS = 150;
   localparam int BRAKE_CLOSE_MS = 1000;
   localparam int STALL_TIME_MS = 200;
   localparam logic [7:0] STALL_PCT_RST = 8'h1e;
   localparam logic [31:0] STEP_RST = 32'h0000_0064;
   localparam logic [31:0] IDLE_RST = 32'h0000_03e8;
   localparam logic [31:0] UPLIM_RST = 32'h0001_8b50;
   localparam logic [31:0] LOLIM_RST = 32'h0000_04b0;
   localparam logic [31:0] BACKOFF_RST = 32'h0000_0004;
   localparam logic [31:0] POS_RST = 32'h0000_c800;
   localparam int FRICTION_IDLE_MS = 50;
   // Timer units: one tick per millisecond
   localparam int MS_CYCLES = CLK_HZ / 1000;
   localparam int STEP_PERIOD = 1000;
   typedef enum logic [2:0] {
      ST_IDLE, ST_BRAKE_WAIT, ST_BACKOFF, ST_STEP, ST_HOLD, ST_CONT,
      ST_LOCK
   } jkb_state_t;
endpackage

// ---- jkb_keypad.sv ----
// Behavioural model of the two external jog keys.
// Assumes the bench commands each press as a level per clock.
`timescale 1ns/1ns
`default_nettype none
module jkb_keypad
(
   input wire logic i_clock,
   input wire logic [1:0] i_press,
   output logic o_key_up,
   output logic o_key_dn
);
   // Keys follow the command one cycle later
   always_ff @(posedge i_clock)
   begin
      o_key_up <= i_press[0];
      o_key_dn <= i_press[1];
   end
endmodule
`default_nettype wire

// ---- jog_key_and_brake_control_test.sv ----
// Self-checking bench for the jog key and brake control.
// Assumes the keypad model and an Avalon-MM slave with waitrequest.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
   $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module jog_key_and_brake_control_test;
   import jkb_pkg::*;
   logic i_clock = 0;
   logic i_reset = 1;
   logic [5:0] adr = '0;
   logic rd = 0;
   logic wr = 0;
   logic bus = 0;
   logic preop = 0;
   logic [31:0] wdat = '0;
   logic [31:0] rdat;
   logic [6:0] node = '0;
   logic [1:0] press = '0;
   logic ku, kd, wreq, pulse, dir, lastdir;
   logic slow = 0;
   logic brk, mov;
   logic [63:0] q[$];
   int checks = 0;
   int bad_count = 0;
   int np = 0;
   int got, i;
   logic [3:0] ridx[7] = '{REG_STEP, REG_IDLE, REG_UPLIM, REG_LOLIM,
      REG_BACKOFF, REG_POS, 4'hf};
   logic [31:0] rval[7] = '{STEP_RST, IDLE_RST, UPLIM_RST, LOLIM_RST,
      BACKOFF_RST, POS_RST, 32'h0};
   logic [31:0] cw;
   logic k;
   initial
   begin
      forever #5 i_clock = ~i_clock;
   end
   jkb_keypad KEYS (.i_clock(i_clock), .i_press(press), .o_key_up(ku),
      .o_key_dn(kd));
   jkb_jog_ctrl #(.CLOSE_MS(1), .WAIT_MS(1), .TICK_CYCLES(64)) DUT (
      .i_clock(i_clock),
      .i_reset(i_reset), .i_avs_address(adr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(rdat),
      .o_avs_waitrequest(wreq), .i_key_up(ku), .i_key_dn(kd),
      .i_bus_connected(bus), .i_preop(preop), .i_node_address(node),
      .i_speed_low(slow), .o_step_pulse(pulse), .o_step_dir_up(dir),
      .o_brake_release(brk), .o_moving(mov));
   // Pulse counter and read-data monitor
   always @(posedge i_clock)
   begin
      if (pulse === 1'b1)
      begin
         np++;
         lastdir = dir;
      end
   end
   always @(posedge i_clock)
   begin
      if (rd && wreq === 1'b0 && q.size() > 0)
      begin
         `CHK(rdat & q[0][63:32], q[0][31:0])
         void'(q.pop_front());
      end
   end
   task report_and_stop();
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // One Avalon access; for a read d is the expected masked value
   task automatic acc(input logic w, input logic [3:0] x,
      input logic [31:0] d, input logic [31:0] m);
      int n;
      @(posedge i_clock);
      adr <= {x, 2'b00};
      rd <= !w;
      wr <= w;
      wdat <= d;
      if (!w)
         q.push_back({m, d & m});
      n = 0;
      do begin @(posedge i_clock); n++; end while (wreq !== 1'b0 && n < 50);
      if (n >= 50)
      begin
         bad_count++;
         report_and_stop();
      end
      rd <= 0;
      wr <= 0;
   endtask
   task automatic wc(input logic [31:0] v);
      if (v[CW_JOG_REL])
         v[CW_BUS_REL] = 1'b0;
      cw = v;
      acc(1, REG_CTRL, v, 0);
   endtask
   task automatic jog(input logic [1:0] p, input int hold);
      int n0;
      n0 = np;
      @(posedge i_clock);
      press <= p;
      repeat (hold) @(posedge i_clock);
      press <= 2'b00;
      repeat (400) @(posedge i_clock);
      got = np - n0;
   endtask
   function automatic logic [31:0] en_exp();
      logic ke, se;
      ke = bus ? ((cw[CW_JOG_REL] && !cw[CW_BUS_REL]) || (k && preop))
         : (node <= 1 || k);
      se = bus && !cw[CW_BUS_REL] && !cw[CW_JOG_REL] && (!k || !preop);
      return {29'h0, ke, se, 1'b0};
   endfunction
   initial
   begin
      void'($urandom(26147));
      repeat (5) @(posedge i_clock);
      i_reset <= 0;
      acc(1, 4'hf, 32'h5a5a_5a5a, 0);
      for (i = 0; i < 7; i++)
         acc(0, ridx[i], rval[i], 32'hffff_ffff);
      $display("test reset values done");
      for (i = 0; i < 24; i++)
      begin
         @(posedge i_clock);
         bus <= $urandom % 2;
         preop <= $urandom % 2;
         node <= $urandom % 4;
         k = $urandom % 2;
         acc(1, REG_KEYEN, {31'h0, k}, 0);
         wc(($urandom % 4) << CW_BUS_REL);
         acc(0, REG_STAT, en_exp(), 32'h6);
      end
      $display("test key enable table done");
      @(posedge i_clock);
      bus <= 0;
      preop <= 0;
      node <= 0;
      wc(0);
      acc(1, REG_STEP, 5, 0);
      acc(1, REG_IDLE, 0, 0);
      acc(1, REG_CFG, 0, 0);
      jog(2'b01, 2);
      `CHK(got, 5)
      `CHK(lastdir, 1'b1)
      jog(2'b10, 300);
      `CHK(got > 5, 1'b1)
      `CHK(lastdir, 1'b0)
      @(posedge i_clock);
      bus <= 1;
      wc(1 << CW_JOG_REL);
      jog(2'b01, 300);
      `CHK(got, 5)
      wc((1 << CW_JOG_REL) | (1 << CW_CONT_REL));
      jog(2'b01, 300);
      `CHK(got > 5, 1'b1)
      for (i = 0; i < 2; i++)
      begin
         wc(1 << (CW_SIM_UP + i));
         jog(2'b00, 0);
         wc(0);
         `CHK(got > 0, 1'b1)
         `CHK(lastdir, i == 0)
      end
      $display("test single and continuous steps done");
      wc((1 << CW_JOG_REL) | (1 << CW_CONT_REL));
      @(posedge i_clock);
      press <= 2'b01;
      repeat (40) @(posedge i_clock);
      wc(1 << CW_BUS_REL);
      repeat (4) @(posedge i_clock);
      got = np;
      repeat (100) @(posedge i_clock);
      `CHK(np - got, 0)
      press <= 2'b00;
      wc(1 << CW_JOG_REL);
      @(posedge i_clock);
      press <= 2'b01;
      repeat (3) @(posedge i_clock);
      press <= 2'b11;
      repeat (4) @(posedge i_clock);
      got = np;
      press <= 2'b10;
      repeat (100) @(posedge i_clock);
      `CHK(np - got, 0)
      press <= 2'b00;
      repeat (3) @(posedge i_clock);
      jog(2'b01, 2);
      `CHK(got, 5)
      $display("test aborts done");
      acc(1, REG_STALLTIM, 100, 0);
      acc(1, REG_STALLPCT, 60, 0);
      slow <= 1;
      wc((1 << CW_BUS_REL) | (1 << CW_MAN_UP));
      repeat (20) @(posedge i_clock);
      `CHK(mov, 1'b1)
      acc(0, REG_STAT, 32'h40, 32'h440);
      repeat (5800) @(posedge i_clock);
      acc(0, REG_STAT, 32'h40, 32'h440);
      repeat (1200) @(posedge i_clock);
      acc(0, REG_STAT, 32'h400, 32'h440);
      `CHK(mov, 1'b0)
      slow <= 0;
      wc((1 << CW_BUS_REL) | (1 << CW_MAN_DN));
      repeat (40) @(posedge i_clock);
      acc(0, REG_STAT, 32'h40, 32'h440);
      `CHK(lastdir, 1'b0)
      wc(0);
      $display("test stall done");
      bus <= 0;
      acc(1, REG_CFG, 1, 0);
      i = np;
      press <= 2'b01;
      repeat (150) @(posedge i_clock);
      `CHK(brk, 1'b1)
      press <= 2'b00;
      repeat (400) @(posedge i_clock);
      `CHK(np - i, 9)
      `CHK(brk, 1'b0)
      acc(1, REG_CFG, 2, 0);
      i = np;
      press <= 2'b01;
      repeat (2) @(posedge i_clock);
      press <= 2'b00;
      repeat (3000) @(posedge i_clock);
      `CHK(np - i, 0)
      repeat (400) @(posedge i_clock);
      `CHK(np - i, 5)
      `CHK(brk, 1'b0)
      acc(1, REG_CFG, 0, 0);
      $display("test brakes done");
      acc(1, REG_UPLIM, 32'h1, 0);
      acc(1, REG_LOLIM, 32'h0001_0000, 0);
      jog(2'b01, 2);
      `CHK(got, 0)
      jog(2'b10, 2);
      `CHK(got, 0)
      $display("test travel limits done");
      report_and_stop();
   end
endmodule
`default_nettype wire
